/* include/i2c_seq_pkg.sv */
package i2c_seq_pkg;
	// register byte addresses
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STAT_OFS = 8'h04;
	// control fields
	localparam int SEQ_LSB = 0;
	localparam int SEQ_W = 5;
	localparam int ACKBIT_POS = 5;
	localparam int STRETCH_POS = 6;
	localparam int GCALL_POS = 7;
	localparam int REL_POS = 12;
	localparam int ON_POS = 15;
	localparam logic [31:0] CTRL_MASK = 32'h0000_90FF;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	// status fields
	localparam int RX_LSB = 0;
	localparam int GCFLAG_POS = 8;
	localparam int BUSY_POS = 9;
	// sequence codes, one bit each, in control-bit order
	localparam logic [4:0] SEQ_START = 5'h01;
	localparam logic [4:0] SEQ_RSTART = 5'h02;
	localparam logic [4:0] SEQ_STOP = 5'h04;
	localparam logic [4:0] SEQ_RECV = 5'h08;
	localparam logic [4:0] SEQ_ACK = 5'h10;
	// bus timing: one quarter of a 100 kHz bit, least time
	localparam int QTR_NS = 2500;
	localparam int LINK_PERIOD_PS = 15000;
	localparam int QTR_CYC = (QTR_NS * 1000 + LINK_PERIOD_PS - 1) /
		LINK_PERIOD_PS;
	localparam logic [7:0] QTR_LAST = 8'(QTR_CYC - 1);
	typedef struct packed {
		logic on;
		logic rel;
		logic gcall;
		logic stretch;
		logic ackBit;
	} cfg_type;
	typedef struct packed {
		logic scl;
		logic sda;
	} pins_type;
	typedef enum logic [5:0] {
		ST_IDLE = 6'b000001,
		ST_START = 6'b000010,
		ST_RSTART = 6'b000100,
		ST_STOP = 6'b001000,
		ST_RECV = 6'b010000,
		ST_ACK = 6'b100000
	} lstate_type;
endpackage : i2c_seq_pkg

/* logic/i2c_bus_sequence_control.sv */
// Operation
// - general call address flagged only when enabled
// - ack enable starts master acknowledge sequence
// - ack enable self-clears when sequence ends
// - receive enable takes one byte, then clears
// - stop enable makes Stop, then clears
// - repeated start enable makes Repeated Start, clears
// - start enable makes Start, then clears
//
// Design decisions made here: the APB register port and the register offsets.
`timescale 1ns/1ps
module i2c_bus_sequence_control (
	// system
	input wire logic mclk,
	input wire logic arst_n,
	// apb slave
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// link clock
	input wire logic linkClk,
	// open-drain bus pins
	input wire logic sclIn,
	output logic sclOut,
	output logic sclOe,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOe
);
	function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
		hit = (a == o);
	endfunction : hit
	// mclk domain
	logic [31:0] ctrlQ, ctrlD, prdataQ, prdataD;
	logic preadyQ, preadyD, pslverrQ, pslverrD;
	logic busyQ, busyD, gcFlagQ, gcFlagD, reqTglQ, reqTglD;
	logic [4:0] cmdQ, cmdD, newSeq;
	logic [7:0] rxQ, rxD, rxByteQ;
	logic [2:0] doneSyncQ, gcSyncQ;
	logic doneEdge, gcEdge, wrAcc, mapped, doneTglQ, gcTglQ;
	assign doneEdge = doneSyncQ[2] ^ doneSyncQ[1];
	assign gcEdge = gcSyncQ[2] ^ gcSyncQ[1];
	assign wrAcc = psel & penable & preadyQ & pwrite;
	assign mapped = hit(paddr, i2c_seq_pkg::CTRL_OFS) |
		hit(paddr, i2c_seq_pkg::STAT_OFS);
	assign newSeq = pwdata[i2c_seq_pkg::SEQ_LSB +: i2c_seq_pkg::SEQ_W];
	always_comb begin
		ctrlD = ctrlQ;
		busyD = busyQ;
		gcFlagD = gcFlagQ;
		rxD = rxQ;
		reqTglD = reqTglQ;
		cmdD = cmdQ;
		prdataD = prdataQ;
		preadyD = psel & ~penable;
		pslverrD = psel & ~penable & ~mapped;
		if (psel & ~penable) begin
			if (hit(paddr, i2c_seq_pkg::CTRL_OFS)) begin
				prdataD = ctrlQ;
			end else if (hit(paddr, i2c_seq_pkg::STAT_OFS)) begin
				prdataD = '0;
				prdataD[i2c_seq_pkg::RX_LSB +: 8] = rxQ;
				prdataD[i2c_seq_pkg::GCFLAG_POS] = gcFlagQ;
				prdataD[i2c_seq_pkg::BUSY_POS] = busyQ;
			end else begin
				prdataD = '0;
			end
		end
		if (wrAcc && hit(paddr, i2c_seq_pkg::CTRL_OFS)) begin
			ctrlD = pwdata & i2c_seq_pkg::CTRL_MASK;
			ctrlD[i2c_seq_pkg::SEQ_LSB +: i2c_seq_pkg::SEQ_W] =
				busyQ ? cmdQ : '0;
			if (!busyQ && pwdata[i2c_seq_pkg::ON_POS] && $onehot(newSeq)) begin
				ctrlD[i2c_seq_pkg::SEQ_LSB +: i2c_seq_pkg::SEQ_W] = newSeq;
				cmdD = newSeq;
				reqTglD = ~reqTglQ;
				busyD = 1'b1;
			end
		end
		if (wrAcc && hit(paddr, i2c_seq_pkg::STAT_OFS) &&
			pwdata[i2c_seq_pkg::GCFLAG_POS]) begin
			gcFlagD = 1'b0;
		end
		if (gcEdge) begin
			gcFlagD = 1'b1;
		end
		if (doneEdge) begin
			ctrlD[i2c_seq_pkg::SEQ_LSB +: i2c_seq_pkg::SEQ_W] = '0;
			busyD = 1'b0;
			if (cmdQ == i2c_seq_pkg::SEQ_RECV) begin
				rxD = rxByteQ;
			end
		end
	end
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			ctrlQ <= i2c_seq_pkg::CTRL_RESET;
			prdataQ <= '0;
			preadyQ <= 1'b0;
			pslverrQ <= 1'b0;
			busyQ <= 1'b0;
			gcFlagQ <= 1'b0;
			rxQ <= '0;
			reqTglQ <= 1'b0;
			cmdQ <= '0;
			doneSyncQ <= '0;
			gcSyncQ <= '0;
		end else begin
			ctrlQ <= ctrlD;
			prdataQ <= prdataD;
			preadyQ <= preadyD;
			pslverrQ <= pslverrD;
			busyQ <= busyD;
			gcFlagQ <= gcFlagD;
			rxQ <= rxD;
			reqTglQ <= reqTglD;
			cmdQ <= cmdD;
			doneSyncQ <= {doneSyncQ[1:0], doneTglQ};
			gcSyncQ <= {gcSyncQ[1:0], gcTglQ};
		end
	end
	assign prdata = prdataQ;
	assign pready = preadyQ;
	assign pslverr = pslverrQ;
	// link domain
	i2c_seq_pkg::cfg_type cfgRaw, cfgS1Q, cfgS2Q;
	i2c_seq_pkg::pins_type pinS1Q, pinS2Q, pinS3Q;
	i2c_seq_pkg::lstate_type stQ, stD;
	logic [7:0] tickQ, tickD, shQ, shD, rxByteD, slvShQ, slvShD;
	logic [1:0] qtrQ, qtrD;
	logic [2:0] reqSyncQ, bitQ, bitD;
	logic [3:0] slvCntQ, slvCntD;
	logic ownQ, ownD, doneTglD, gcTglD, slvActQ, slvActD, holdQ, holdD;
	logic sclDrv, sdaDrv, stall, reqEdge, sclRise, sclFall;
	assign cfgRaw = '{on: ctrlQ[i2c_seq_pkg::ON_POS],
		rel: ctrlQ[i2c_seq_pkg::REL_POS],
		gcall: ctrlQ[i2c_seq_pkg::GCALL_POS],
		stretch: ctrlQ[i2c_seq_pkg::STRETCH_POS],
		ackBit: ctrlQ[i2c_seq_pkg::ACKBIT_POS]};
	assign reqEdge = reqSyncQ[2] ^ reqSyncQ[1];
	assign sclRise = ~pinS3Q.scl & pinS2Q.scl;
	assign sclFall = pinS3Q.scl & ~pinS2Q.scl;
	// pin drive per quarter, 1 pulls the line low
	always_comb begin
		sclDrv = 1'b0;
		sdaDrv = 1'b0;
		case (stQ)
			i2c_seq_pkg::ST_IDLE: sclDrv = ownQ | holdQ;
			i2c_seq_pkg::ST_START: begin
				sdaDrv = (qtrQ != 2'd0);
				sclDrv = (qtrQ == 2'd3);
			end
			i2c_seq_pkg::ST_RSTART: begin
				sdaDrv = qtrQ[1];
				sclDrv = (qtrQ == 2'd0) | (qtrQ == 2'd3);
			end
			i2c_seq_pkg::ST_STOP: begin
				sdaDrv = ~qtrQ[1];
				sclDrv = (qtrQ == 2'd0);
			end
			i2c_seq_pkg::ST_RECV: begin
				sclDrv = (qtrQ == 2'd0) | (qtrQ == 2'd3);
			end
			i2c_seq_pkg::ST_ACK: begin
				sdaDrv = ~cfgS2Q.ackBit;
				sclDrv = (qtrQ == 2'd0) | (qtrQ == 2'd3);
			end
			default: sclDrv = 1'b0;
		endcase
	end

	// wait while another party holds the clock low
	assign stall = (qtrQ == 2'd1) & ~sclDrv & ~pinS2Q.scl;
	always_comb begin
		stD = stQ;
		tickD = tickQ;
		qtrD = qtrQ;
		bitD = bitQ;
		shD = shQ;
		rxByteD = rxByteQ;
		ownD = ownQ;
		doneTglD = doneTglQ;
		if (stQ == i2c_seq_pkg::ST_IDLE) begin
			if (reqEdge) begin
				tickD = '0;
				qtrD = '0;
				bitD = '0;
				if (cfgS2Q.on) begin
					stD = i2c_seq_pkg::lstate_type'({cmdQ, 1'b0});
				end else begin
					doneTglD = ~doneTglQ;
				end
			end
		end else if (!cfgS2Q.on) begin
			stD = i2c_seq_pkg::ST_IDLE;
			ownD = 1'b0;
			doneTglD = ~doneTglQ;
		end else if (!stall) begin
			tickD = tickQ + 8'd1;
			if (tickQ == i2c_seq_pkg::QTR_LAST) begin
				tickD = '0;
				qtrD = qtrQ + 2'd1;
				if (qtrQ == 2'd2 && stQ == i2c_seq_pkg::ST_RECV) begin
					shD = {shQ[6:0], pinS2Q.sda};
				end
				if (qtrQ == 2'd3) begin
					if (stQ == i2c_seq_pkg::ST_RECV && bitQ != 3'd7) begin
						bitD = bitQ + 3'd1;
					end else begin
						stD = i2c_seq_pkg::ST_IDLE;
						doneTglD = ~doneTglQ;
						ownD = (stQ != i2c_seq_pkg::ST_STOP);
						if (stQ == i2c_seq_pkg::ST_RECV) begin
							rxByteD = shQ;
						end
					end
				end
			end
		end
	end

	// slave-side watch for the general call address
	always_comb begin
		slvActD = slvActQ;
		slvCntD = slvCntQ;
		slvShD = slvShQ;
		gcTglD = gcTglQ;
		holdD = holdQ & cfgS2Q.stretch & ~cfgS2Q.rel & cfgS2Q.on;
		if (stQ != i2c_seq_pkg::ST_IDLE || ownQ || !cfgS2Q.on) begin
			slvActD = 1'b0;
		end else if (pinS2Q.scl && pinS3Q.sda && !pinS2Q.sda) begin
			slvActD = 1'b1;
			slvCntD = '0;
		end else if (pinS2Q.scl && !pinS3Q.sda && pinS2Q.sda) begin
			slvActD = 1'b0;
		end else if (slvActQ && sclRise && slvCntQ != 4'd8) begin
			slvShD = {slvShQ[6:0], pinS2Q.sda};
			slvCntD = slvCntQ + 4'd1;
			if (slvCntQ == 4'd7 && {slvShQ[6:0], pinS2Q.sda} == 8'h00 &&
				cfgS2Q.gcall) begin
				gcTglD = ~gcTglQ;
			end
		end else if (slvActQ && sclFall && slvCntQ == 4'd8) begin
			slvActD = 1'b0;
			holdD = cfgS2Q.stretch & ~cfgS2Q.rel;
		end
	end

	always_ff @(posedge linkClk or negedge arst_n) begin
		if (!arst_n) begin
			cfgS1Q <= '0;
			cfgS2Q <= '0;
			pinS1Q <= '1;
			pinS2Q <= '1;
			pinS3Q <= '1;
			reqSyncQ <= '0;
			stQ <= i2c_seq_pkg::ST_IDLE;
			tickQ <= '0;
			qtrQ <= '0;
			bitQ <= '0;
			shQ <= '0;
			rxByteQ <= '0;
			ownQ <= 1'b0;
			doneTglQ <= 1'b0;
			slvActQ <= 1'b0;
			slvCntQ <= '0;
			slvShQ <= '0;
			gcTglQ <= 1'b0;
			holdQ <= 1'b0;
			sclOe <= 1'b0;
			sdaOe <= 1'b0;
			sclOut <= 1'b0;
			sdaOut <= 1'b0;
		end else begin
			cfgS1Q <= cfgRaw;
			cfgS2Q <= cfgS1Q;
			pinS1Q <= '{scl: sclIn, sda: sdaIn};
			pinS2Q <= pinS1Q;
			pinS3Q <= pinS2Q;
			reqSyncQ <= {reqSyncQ[1:0], reqTglQ};
			stQ <= stD;
			tickQ <= tickD;
			qtrQ <= qtrD;
			bitQ <= bitD;
			shQ <= shD;
			rxByteQ <= rxByteD;
			ownQ <= ownD;
			doneTglQ <= doneTglD;
			slvActQ <= slvActD;
			slvCntQ <= slvCntD;
			slvShQ <= slvShD;
			gcTglQ <= gcTglD;
			holdQ <= holdD;
			sclOe <= sclDrv;
			sdaOe <= sdaDrv;
			sclOut <= 1'b0;
			sdaOut <= 1'b0;
		end
	end
	// checks
	AST_GC_SETS: assert property (@(posedge mclk) disable iff (!arst_n)
		gcEdge |=> gcFlagQ) else $error("general call not flagged");
	AST_ONE_SEQ: assert property (@(posedge mclk) disable iff (!arst_n)
		$onehot0(ctrlQ[4:0]) && (busyQ || ctrlQ[4:0] == 5'h00))
		else $error("sequence bits inconsistent");
	AST_SEQ_CLEARS: assert property (@(posedge mclk) disable iff (!arst_n)
		doneEdge |=> ctrlQ[4:0] == 5'h00 && !busyQ)
		else $error("sequence bit not cleared");
	AST_ACK_LEVEL: assert property (@(posedge linkClk) disable iff (!arst_n)
		stQ == i2c_seq_pkg::ST_ACK |=> sdaOe == ~cfgS2Q.ackBit)
		else $error("ack level wrong");
	AST_START_SHAPE: assert property (@(posedge linkClk)
		disable iff (!arst_n) stQ == i2c_seq_pkg::ST_START && qtrQ == 2'd1
		|=> sdaOe && !sclOe) else $error("start shape wrong");
	AST_RSTART_SHAPE: assert property (@(posedge linkClk)
		disable iff (!arst_n) stQ == i2c_seq_pkg::ST_RSTART && qtrQ == 2'd2
		|=> sdaOe && !sclOe) else $error("repeated start shape wrong");
	AST_STOP_SHAPE: assert property (@(posedge linkClk)
		disable iff (!arst_n) stQ == i2c_seq_pkg::ST_STOP && qtrQ == 2'd2
		|=> !sdaOe && !sclOe) else $error("stop shape wrong");
	AST_RECV_FREE: assert property (@(posedge linkClk)
		disable iff (!arst_n) stQ == i2c_seq_pkg::ST_RECV |=> !sdaOe)
		else $error("data driven in receive");
	AST_STRETCH: assert property (@(posedge linkClk)
		disable iff (!arst_n) holdQ |=> sclOe) else $error("stretch lost");
	AST_APB_ERR: assert property (@(posedge mclk) disable iff (!arst_n)
		psel && !penable && !mapped |=> pready && pslverr)
		else $error("unmapped access not refused");
endmodule : i2c_bus_sequence_control

/* tb/i2c_bus_partner.sv */
`timescale 1ns/1ps
module i2c_bus_partner (
	// link side
	input wire logic linkClk,
	input wire logic scl,
	input wire logic sda,
	// bench control
	input wire logic talk,
	input wire logic [7:0] txByte,
	input wire logic [9:0] stretch,
	// pulls, high pulls the line low
	output logic sclPull,
	output logic sdaPull
);
	logic [3:0] bitIdx = 4'h0;
	logic [9:0] holdCnt = 10'h000;
	logic sclLast = 1'h1;
	logic mScl = 1'h0;
	logic mSda = 1'h0;
	// answer bit changes only after scl falls, msb first
	assign sdaPull = mSda | (talk && bitIdx < 4'h8 &&
		!txByte[3'h7 - bitIdx[2:0]]);
	assign sclPull = mScl | (holdCnt != 10'h000);
	always @(posedge linkClk) begin
		sclLast <= scl;
		if (!talk)
			bitIdx <= 4'h0;
		else if (sclLast && !scl)
			bitIdx <= bitIdx + 4'h1;
		if (sclLast && !scl)
			holdCnt <= stretch;
		else if (holdCnt != 10'h000)
			holdCnt <= holdCnt - 10'h001;
	end
	task automatic quarter;
		repeat (i2c_seq_pkg::QTR_CYC) @(posedge linkClk);
	endtask : quarter
	// start, eight bits, then scl let go
	task automatic frame(input logic [7:0] b);
		mSda <= 1'h1;
		quarter();
		mScl <= 1'h1;
		for (int i = 7; i >= 0; i--) begin
			mSda <= !b[i];
			quarter();
			mScl <= 1'h0;
			quarter();
			mScl <= 1'h1;
		end
		quarter();
		mSda <= 1'h0;
		mScl <= 1'h0;
	endtask : frame
	task automatic stop;
		mScl <= 1'h1;
		mSda <= 1'h1;
		quarter();
		mScl <= 1'h0;
		quarter();
		mSda <= 1'h0;
		quarter();
	endtask : stop
endmodule : i2c_bus_partner

/* tb/test_i2c_bus_sequence_control.sv */
`timescale 1ns/1ps
module test_i2c_bus_sequence_control;
	typedef struct packed {
		logic [15:0] ctrl;
		logic [7:0] tx;
		logic midScl;
		logic midSda;
		logic endScl;
	} row_type;
	localparam logic [7:0] ctrlAddr = i2c_seq_pkg::CTRL_OFS;
	localparam logic [7:0] statAddr = i2c_seq_pkg::STAT_OFS;
	logic mclk = 1'h0;
	logic linkClk = 1'h0;
	logic arst_n = 1'h0;
	logic [7:0] paddr = 8'h00;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready, pslverr, sclOe, sdaOe, pScl, pSda, err, sclO, sdaO;
	logic talk = 1'h0;
	logic [7:0] txByte = 8'h00;
	logic [9:0] stretch = 10'h000;
	logic [31:0] rd;
	logic [7:0] rxExp = 8'h00;
	int n_mismatch = 0;
	int check_count = 0;
	wire scl = !(sclOe | pScl);
	wire sda = !(sdaOe | pSda);
	row_type rows [7] = '{
		'{16'h8001, 8'h00, 1'h0, 1'h1, 1'h1},
		'{16'h8008, 8'hA5, 1'h0, 1'h0, 1'h1},
		'{16'h8010, 8'h00, 1'h0, 1'h1, 1'h1},
		'{16'h8002, 8'h00, 1'h0, 1'h1, 1'h1},
		'{16'h8008, 8'h3C, 1'h0, 1'h0, 1'h1},
		'{16'h8030, 8'h00, 1'h0, 1'h0, 1'h1},
		'{16'h8004, 8'h00, 1'h0, 1'h0, 1'h0}};
	i2c_bus_sequence_control dut (.mclk(mclk), .arst_n(arst_n),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .linkClk(linkClk), .sclIn(scl), .sclOut(sclO),
		.sclOe(sclOe), .sdaIn(sda), .sdaOut(sdaO), .sdaOe(sdaOe));
	i2c_bus_partner partner (.linkClk(linkClk), .scl(scl), .sda(sda),
		.talk(talk), .txByte(txByte), .stretch(stretch),
		.sclPull(pScl), .sdaPull(pSda));
	initial begin
		forever #12.5 mclk = !mclk;
	end
	initial begin
		#3.3;
		forever #7.5 linkClk = !linkClk;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'h1;
		do @(posedge mclk); while (pready !== 1'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge mclk);
	endtask : apb
	task automatic waitDone;
		do apb(1'h0, ctrlAddr, 32'h0000_0000); while (rd[4:0] !== 5'h00);
	endtask : waitDone
	task automatic results;
		$display("mismatches %0d checks %0d", n_mismatch, check_count);
		if (n_mismatch == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : results
	initial begin
		repeat (40000) @(posedge mclk);
		n_mismatch++;
		results();
	end
	initial begin
		repeat (16) @(posedge mclk);
		arst_n <= 1'h1;
		repeat (4) @(posedge mclk);
		apb(1'h0, ctrlAddr, 32'h0000_0000);
		chk(rd, i2c_seq_pkg::CTRL_RESET);
		foreach (rows[i]) begin
			talk <= rows[i].ctrl[3];
			txByte <= rows[i].tx;
			stretch <= (i == 4) ? 10'h258 : 10'h000;
			apb(1'h1, ctrlAddr, {16'h0000, rows[i].ctrl});
			repeat (250) @(posedge mclk);
			chk(32'({sclOe, sdaOe}), 32'({rows[i].midScl, rows[i].midSda}));
			apb(1'h0, ctrlAddr, 32'h0000_0000);
			chk(rd, {16'h0000, rows[i].ctrl});
			waitDone();
			if (rows[i].ctrl[3])
				rxExp = rows[i].tx;
			apb(1'h0, statAddr, 32'h0000_0000);
			chk(32'(rd[9:0]), 32'(rxExp));
			chk(32'(sclOe), 32'(rows[i].endScl));
		end
		// second request while busy is dropped
		apb(1'h1, ctrlAddr, 32'h0000_8001);
		apb(1'h1, ctrlAddr, 32'h0000_8004);
		apb(1'h0, ctrlAddr, 32'h0000_0000);
		chk(rd, 32'h0000_8001);
		apb(1'h0, statAddr, 32'h0000_0000);
		chk(32'(rd[i2c_seq_pkg::BUSY_POS]), 32'h0000_0001);
		waitDone();
		apb(1'h1, ctrlAddr, 32'h0000_8004);
		waitDone();
		chk(32'({scl, sda}), 32'h0000_0003);
		apb(1'h1, ctrlAddr, 32'h0000_8003);
		apb(1'h0, ctrlAddr, 32'h0000_0000);
		chk(rd, 32'h0000_8000);
		apb(1'h1, 8'h08, 32'h0000_80C0);
		chk(32'(err), 32'h0000_0001);
		apb(1'h0, 8'h08, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		apb(1'h1, ctrlAddr, 32'h0000_80C0);
		partner.frame(8'h00);
		repeat (20) @(posedge mclk);
		chk(32'({scl, sclOe}), 32'h0000_0001);
		apb(1'h0, statAddr, 32'h0000_0000);
		chk(32'(rd[8]), 32'h0000_0001);
		apb(1'h1, ctrlAddr, 32'h0000_90C0);
		repeat (20) @(posedge mclk);
		chk(32'(sclOe), 32'h0000_0000);
		partner.stop();
		apb(1'h1, statAddr, 32'h0000_0100);
		apb(1'h1, ctrlAddr, 32'h0000_8000);
		partner.frame(8'h00);
		chk(32'(sclOe), 32'h0000_0000);
		partner.stop();
		apb(1'h0, statAddr, 32'h0000_0000);
		chk(32'(rd[8]), 32'h0000_0000);
		// disabling the module aborts a running start
		apb(1'h1, ctrlAddr, 32'h0000_8001);
		repeat (100) @(posedge mclk);
		apb(1'h1, ctrlAddr, 32'h0000_0000);
		@(posedge mclk);
		waitDone();
		chk(rd, 32'h0000_0000);
		chk(32'({sclOe, sdaOe}), 32'h0000_0000);
		// reset in mid sequence
		apb(1'h1, ctrlAddr, 32'h0000_8001);
		repeat (100) @(posedge mclk);
		arst_n <= 1'h0;
		repeat (4) @(posedge mclk);
		chk(32'({sclOe, sdaOe, pready, sclO, sdaO}), 32'h0000_0000);
		arst_n <= 1'h1;
		repeat (4) @(posedge mclk);
		apb(1'h0, ctrlAddr, 32'h0000_0000);
		chk(rd, i2c_seq_pkg::CTRL_RESET);
		results();
	end
endmodule : test_i2c_bus_sequence_control
